// >>> verilog/drl_regs.svh
`ifndef DRL_REGS_SVH
`define DRL_REGS_SVH

// Time base
`define DRL_CLK_PERIOD_PS   5000
`define DRL_MS_PS           1000000000
`define DRL_MS_CYCLES       (`DRL_MS_PS / `DRL_CLK_PERIOD_PS)
`define DRL_MS_CNT_W        18

// Channel counts and widths
`define DRL_NUM_IN          12
`define DRL_NUM_OUT         8
`define DRL_MS_W            16
`define DRL_OCC_W           7

// Default and limit values
`define DRL_TOGGLE_DEF_MS   16'h01F4
`define DRL_OCC_MAX         7'h7F
`define DRL_FMI_LAST_RANGE  5'h15
`define DRL_FMI_EXISTS      5'h1F

`endif

// >>> verilog/drl_pkg.sv
package drl_pkg;

    typedef enum logic [1:0] {
        DRL_IN_NORMAL  = 2'h0,
        DRL_IN_INVERSE = 2'h1,
        DRL_IN_LATCHED = 2'h2
    } drl_in_type_t;

    typedef enum logic [2:0] {
        DRL_OUT_NONE     = 3'h0,
        DRL_OUT_NORMAL   = 3'h1,
        DRL_OUT_INVERSE  = 3'h2,
        DRL_OUT_LATCHED  = 3'h3,
        DRL_OUT_ILATCHED = 3'h4,
        DRL_OUT_TOGGLE   = 3'h5
    } drl_out_type_t;

    typedef enum logic [1:0] {
        DRL_LAMP_PROTECT = 2'h0,
        DRL_LAMP_AMBER   = 2'h1,
        DRL_LAMP_RED     = 2'h2,
        DRL_LAMP_MALF    = 2'h3
    } drl_lamp_t;

    typedef enum {
        DRL_F_IDLE,
        DRL_F_PEND,
        DRL_F_ACTIVE,
        DRL_F_CLEARING
    } drl_fault_t;

endpackage : drl_pkg

// >>> verilog/drl_debounce.sv
`timescale 1ns/1ps
`default_nettype none
`include "drl_regs.svh"

module drl_debounce
    import drl_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Time base and setting
    input  wire logic                  ms_tick,
    input  wire logic [`DRL_MS_W-1:0]  debounce_ms,
    // Level
    input  wire logic                  raw,
    output logic                       level
);

    logic [`DRL_MS_W-1:0] hold_ms;

    // Time the raw level has differed from the accepted one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_ms <= '0;
        end else if (raw == level) begin
            hold_ms <= '0;
        end else if (ms_tick && hold_ms != '1) begin
            hold_ms <= hold_ms + `DRL_MS_W'(1);
        end
    end

    // Accept only after the full debounce time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b1;
        end else if (raw != level && hold_ms >= debounce_ms) begin
            level <= raw;
        end
    end

    AST_DEB_HOLD: assert property (
        @(posedge clk) disable iff (!rst_n)
        (raw != level && hold_ms < debounce_ms) |=> $stable(level))
        else $error("debounce accepted level too early");

endmodule : drl_debounce
`default_nettype wire

// >>> verilog/drl_core.sv
// Function
// - Per-input polarity: 0 active high, 1 active low of pin level; code reads low pin as ON for 0, high pin as ON for 1.
// - Default polarity with pull-up: grounded pin reads as ON.
// - Each input has a configurable debounce time filtering noise.
// - Input type: 0 normal, 1 inverse, 2 latched; normal default.
// - Normal input: state is 1 while ON, 0 while OFF.
// - Inverse input: state is 0 while ON, 1 while OFF.
// - Latched input: state toggles on every OFF-to-ON transition only.
// - Trouble code raised by ON only when generate flag is true.
// - Without request-only clearing, code clears once input no longer ON.
// - Request-only clearing: DM11 clears if not ON; count kept.
// - Occurrence count resets only when a DM3 request arrives.
// - Lamp field: 0 protect, 1 amber, 2 red, 3 malfunction.
// - Failure mode identifier accepts 0 to 21 and 31.
// - Code becomes active after configurable send delay in ms.
// - Input OFF before send delay ends: code never becomes active.
// - Active code clears after separate clear delay once input OFF.
// - Eight relays, each common to normally-open or normally-closed.
// - Relay type: 0 none,1 normal,2 inverse,3 latch,4 inv latch,5 toggle.
// - Inverse relay: open side when source ON, closed side when OFF.
// - Latched relay toggles contact on each source OFF-to-ON.
// - Inverse latched relay toggles contact on each source ON-to-OFF.
// - Toggle relay alternates continuously, each state configurable ms.
`timescale 1ns/1ps
`default_nettype none
`include "drl_regs.svh"

module drl_core
    import drl_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `DRL_MS_CYCLES
)(
    // Clock and reset
    input  wire logic                                    clk,
    input  wire logic                                    resetn,
    // Input pins
    input  wire logic [`DRL_NUM_IN-1:0]                  in_pin,
    // Input configuration
    input  wire logic [`DRL_NUM_IN-1:0]                  in_active_low,
    input  wire logic [`DRL_NUM_IN-1:0][`DRL_MS_W-1:0]   in_debounce_ms,
    input  wire logic [`DRL_NUM_IN-1:0][1:0]             in_type,
    // Fault configuration
    input  wire logic [`DRL_NUM_IN-1:0]                  fault_code_generate_flag,
    input  wire logic [`DRL_NUM_IN-1:0]                  clear_on_request_only_flag,
    input  wire logic [`DRL_NUM_IN-1:0][`DRL_MS_W-1:0]   fault_send_delay,
    input  wire logic [`DRL_NUM_IN-1:0][`DRL_MS_W-1:0]   fault_clear_delay,
    input  wire logic [`DRL_NUM_IN-1:0][1:0]             fault_lamp_select,
    input  wire logic [`DRL_NUM_IN-1:0][4:0]             fault_mode_select,
    // Network requests
    input  wire logic                                    dm11_request,
    input  wire logic                                    dm3_request,
    // Input results
    output logic [`DRL_NUM_IN-1:0]                       input_state,
    output logic [`DRL_NUM_IN-1:0]                       fault_active,
    output logic [`DRL_NUM_IN-1:0][1:0]                  fault_lamp,
    output logic [`DRL_NUM_IN-1:0][4:0]                  fault_mode,
    output logic [`DRL_NUM_IN-1:0][`DRL_OCC_W-1:0]       fault_count,
    // Relay configuration
    input  wire logic [`DRL_NUM_OUT-1:0]                 relay_source,
    input  wire logic [`DRL_NUM_OUT-1:0][2:0]            relay_type,
    input  wire logic [`DRL_NUM_OUT-1:0][`DRL_MS_W-1:0]  relay_toggle_ms,
    // Relay contacts, 1 joins common to normally-open
    output logic [`DRL_NUM_OUT-1:0]                      relay_to_open
);

    logic [1:0]                           rst_sync;
    logic                                 rst_n;
    logic [`DRL_NUM_IN-1:0]               pin_meta;
    logic [`DRL_NUM_IN-1:0]               pin_sync;
    logic [`DRL_NUM_IN-1:0]               pin_db;
    logic [`DRL_NUM_IN-1:0]               on;
    logic [`DRL_NUM_IN-1:0]               on_prev;
    logic                                 on_valid;
    logic [`DRL_MS_CNT_W-1:0]             ms_cnt;
    logic                                 ms_tick;
    drl_fault_t                           fstate [`DRL_NUM_IN];
    drl_fault_t                           next_fstate [`DRL_NUM_IN];
    logic [`DRL_NUM_IN-1:0][`DRL_MS_W-1:0] fault_ms;
    logic [`DRL_NUM_IN-1:0]               next_active;
    logic [`DRL_NUM_IN-1:0]               raise;
    logic [`DRL_NUM_OUT-1:0]              src_prev;
    logic [`DRL_NUM_OUT-1:0][`DRL_MS_W-1:0] tog_ms;

    function automatic logic [`DRL_MS_W-1:0] ms_step(
        input logic [`DRL_MS_W-1:0] v,
        input logic                 tick
    );
        ms_step = (tick && v != '1) ? v + `DRL_MS_W'(1) : v;
    endfunction : ms_step

    // Reset release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Pin synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '1;
            pin_sync <= '1;
        end else begin
            pin_meta <= in_pin;
            pin_sync <= pin_meta;
        end
    end

    // Millisecond time base
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt  <= '0;
            ms_tick <= 1'b0;
        end else if (ms_cnt >= `DRL_MS_CNT_W'(MS_CYCLES - 1)) begin
            ms_cnt  <= '0;
            ms_tick <= 1'b1;
        end else begin
            ms_cnt  <= ms_cnt + `DRL_MS_CNT_W'(1);
            ms_tick <= 1'b0;
        end
    end

    for (genvar i = 0; i < `DRL_NUM_IN; i++) begin : g_deb
        drl_debounce u_deb (
            .clk         (clk),
            .rst_n       (rst_n),
            .ms_tick     (ms_tick),
            .debounce_ms (in_debounce_ms[i]),
            .raw         (pin_sync[i]),
            .level       (pin_db[i])
        );
    end

    // Low pin means ON when active high
    assign on = ~(pin_db ^ in_active_low);

    // Input state mapping
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            input_state <= '0;
            on_prev     <= '0;
            on_valid    <= 1'b0;
        end else begin
            on_prev  <= on;
            on_valid <= 1'b1;
            for (int i = 0; i < `DRL_NUM_IN; i++) begin
                case (drl_in_type_t'(in_type[i]))
                    DRL_IN_NORMAL:  input_state[i] <= on[i];
                    DRL_IN_INVERSE: input_state[i] <= ~on[i];
                    DRL_IN_LATCHED: begin
                        if (on[i] && !on_prev[i] && on_valid) begin
                            input_state[i] <= ~input_state[i];
                        end
                    end
                    default:        input_state[i] <= on[i];
                endcase
            end
        end
    end

    // Fault sequencing
    always_comb begin
        raise = '0;
        for (int i = 0; i < `DRL_NUM_IN; i++) begin
            next_fstate[i] = fstate[i];
            case (fstate[i])
                DRL_F_IDLE: begin
                    if (fault_code_generate_flag[i] && on[i]) begin
                        next_fstate[i] = DRL_F_PEND;
                    end
                end
                DRL_F_PEND: begin
                    if (!on[i]) begin
                        next_fstate[i] = DRL_F_IDLE;
                    end else if (fault_ms[i] >= fault_send_delay[i]) begin
                        next_fstate[i] = DRL_F_ACTIVE;
                        raise[i]       = 1'b1;
                    end
                end
                DRL_F_ACTIVE: begin
                    if (clear_on_request_only_flag[i]) begin
                        if (dm11_request && !on[i]) begin
                            next_fstate[i] = DRL_F_IDLE;
                        end
                    end else if (!on[i]) begin
                        next_fstate[i] = DRL_F_CLEARING;
                    end
                end
                DRL_F_CLEARING: begin
                    if (on[i]) begin
                        next_fstate[i] = DRL_F_ACTIVE;
                    end else if (fault_ms[i] >= fault_clear_delay[i]) begin
                        next_fstate[i] = DRL_F_IDLE;
                    end
                end
                default: next_fstate[i] = DRL_F_IDLE;
            endcase
            if (!fault_code_generate_flag[i]) begin
                next_fstate[i] = DRL_F_IDLE;
                raise[i]       = 1'b0;
            end
            next_active[i] = (next_fstate[i] == DRL_F_ACTIVE) ||
                             (next_fstate[i] == DRL_F_CLEARING);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `DRL_NUM_IN; i++) begin
                fstate[i] <= DRL_F_IDLE;
            end
            fault_ms     <= '0;
            fault_active <= '0;
        end else begin
            fault_active <= next_active;
            for (int i = 0; i < `DRL_NUM_IN; i++) begin
                fstate[i] <= next_fstate[i];
                if (next_fstate[i] != fstate[i]) begin
                    fault_ms[i] <= '0;
                end else begin
                    fault_ms[i] <= ms_step(fault_ms[i], ms_tick);
                end
            end
        end
    end

    // Occurrence count, a new occurrence wins over DM3
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_count <= '0;
        end else begin
            for (int i = 0; i < `DRL_NUM_IN; i++) begin
                if (raise[i]) begin
                    if (dm3_request) begin
                        fault_count[i] <= `DRL_OCC_W'(1);
                    end else if (fault_count[i] != `DRL_OCC_MAX) begin
                        fault_count[i] <= fault_count[i] + `DRL_OCC_W'(1);
                    end
                end else if (dm3_request) begin
                    fault_count[i] <= '0;
                end
            end
        end
    end

    // Reported lamp and failure mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_lamp <= '0;
            fault_mode <= '0;
        end else begin
            for (int i = 0; i < `DRL_NUM_IN; i++) begin
                fault_lamp[i] <= fault_lamp_select[i];
                if (fault_mode_select[i] <= `DRL_FMI_LAST_RANGE) begin
                    fault_mode[i] <= fault_mode_select[i];
                end else begin
                    fault_mode[i] <= `DRL_FMI_EXISTS;
                end
            end
        end
    end

    // Relay contacts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            relay_to_open <= '0;
            src_prev      <= '0;
            tog_ms        <= '0;
        end else begin
            src_prev <= relay_source;
            for (int k = 0; k < `DRL_NUM_OUT; k++) begin
                tog_ms[k] <= '0;
                case (drl_out_type_t'(relay_type[k]))
                    DRL_OUT_NONE:    relay_to_open[k] <= 1'b0;
                    DRL_OUT_NORMAL:  relay_to_open[k] <= relay_source[k];
                    DRL_OUT_INVERSE: relay_to_open[k] <= relay_source[k];
                    DRL_OUT_LATCHED: begin
                        if (relay_source[k] && !src_prev[k]) begin
                            relay_to_open[k] <= ~relay_to_open[k];
                        end
                    end
                    DRL_OUT_ILATCHED: begin
                        if (!relay_source[k] && src_prev[k]) begin
                            relay_to_open[k] <= ~relay_to_open[k];
                        end
                    end
                    DRL_OUT_TOGGLE: begin
                        if (ms_tick && tog_ms[k] + `DRL_MS_W'(1)
                                >= relay_toggle_ms[k]) begin
                            relay_to_open[k] <= ~relay_to_open[k];
                        end else begin
                            tog_ms[k] <= ms_step(tog_ms[k], ms_tick);
                        end
                    end
                    default:         relay_to_open[k] <= 1'b0;
                endcase
            end
        end
    end

    for (genvar i = 0; i < `DRL_NUM_IN; i++) begin : g_ast_in
        AST_IN_NORMAL: assert property (
            @(posedge clk) disable iff (!rst_n)
            (in_type[i] == 2'h0) |=> (input_state[i] == $past(on[i])))
            else $error("normal input state wrong");
        AST_IN_INVERSE: assert property (
            @(posedge clk) disable iff (!rst_n)
            (in_type[i] == 2'h1) |=> (input_state[i] != $past(on[i])))
            else $error("inverse input state wrong");
        AST_IN_LATCH: assert property (
            @(posedge clk) disable iff (!rst_n)
            (in_type[i] == 2'h2 && !(on[i] && !on_prev[i]))
            |=> $stable(input_state[i]))
            else $error("latched input changed without rising edge");
        AST_NO_GEN: assert property (
            @(posedge clk) disable iff (!rst_n)
            !fault_code_generate_flag[i] |=> !fault_active[i])
            else $error("fault raised with generation off");
        AST_EARLY_OFF: assert property (
            @(posedge clk) disable iff (!rst_n)
            (fstate[i] == DRL_F_PEND && !on[i]) |=> !fault_active[i])
            else $error("fault activated after early release");
        AST_DM11_KEEP: assert property (
            @(posedge clk) disable iff (!rst_n)
            (fstate[i] == DRL_F_ACTIVE && clear_on_request_only_flag[i]
             && !dm11_request && !dm3_request && fault_code_generate_flag[i])
            |=> fault_active[i] && $stable(fault_count[i]))
            else $error("fault cleared without DM11");
        AST_DM3_CLEAR: assert property (
            @(posedge clk) disable iff (!rst_n)
            dm3_request |=> (fault_count[i] <= `DRL_OCC_W'(1)))
            else $error("count not reset by DM3");
    end

    for (genvar k = 0; k < `DRL_NUM_OUT; k++) begin : g_ast_out
        AST_RLY_NONE: assert property (
            @(posedge clk) disable iff (!rst_n)
            (relay_type[k] == 3'h0) |=> !relay_to_open[k])
            else $error("unused relay not at rest");
        AST_RLY_NORMAL: assert property (
            @(posedge clk) disable iff (!rst_n)
            (relay_type[k] == 3'h1)
            |=> relay_to_open[k] == $past(relay_source[k]))
            else $error("normal relay wrong side");
        AST_RLY_INVERSE: assert property (
            @(posedge clk) disable iff (!rst_n)
            (relay_type[k] == 3'h2)
            |=> relay_to_open[k] == $past(relay_source[k]))
            else $error("inverse relay wrong side");
        AST_RLY_LATCH: assert property (
            @(posedge clk) disable iff (!rst_n)
            (relay_type[k] == 3'h3 && relay_source[k] && !src_prev[k])
            |=> relay_to_open[k] != $past(relay_to_open[k]))
            else $error("latched relay missed toggle");
        AST_RLY_ILATCH: assert property (
            @(posedge clk) disable iff (!rst_n)
            (relay_type[k] == 3'h4 && !relay_source[k] && src_prev[k])
            |=> relay_to_open[k] != $past(relay_to_open[k]))
            else $error("inverse latched relay missed toggle");
    end

endmodule : drl_core
`default_nettype wire

// >>> bench/drl_field.sv
`timescale 1ns/1ps
`default_nettype none
`include "drl_regs.svh"

module drl_field (
    // Field switches, 1 closes the contact to ground
    input  wire logic [`DRL_NUM_IN-1:0]  sw_closed,
    // Pins seen by the device, idle high through the pull-up
    output logic      [`DRL_NUM_IN-1:0]  in_pin,
    // Relay contacts and the loads behind them
    input  wire logic [`DRL_NUM_OUT-1:0] relay_to_open,
    output logic      [`DRL_NUM_OUT-1:0] load_on
);
    // Open switch leaves the pull-up high, closed switch grounds the pin
    assign in_pin  = ~sw_closed;
    assign load_on = relay_to_open;
endmodule : drl_field
`default_nettype wire

// >>> bench/test_discrete_input_relay_output_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "drl_regs.svh"

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
    n_errors++; $display("MISMATCH t=%0t got=%0h exp=%0h", \
    $time, (got), (exp)); end end

module test_discrete_input_relay_output_logic;
    logic             clk = 1'b0;
    logic             resetn = 1'b0;
    logic [11:0]      sw, pin, act_low, gen, reqo, st, fa;
    logic [11:0][15:0] deb, sdly, cdly;
    logic [11:0][1:0] ityp, lamp, fl;
    logic [11:0][4:0] fmi, fm;
    logic [11:0][6:0] fc;
    logic             dm11, dm3, v;
    logic [7:0]       src, rto, load;
    logic [7:0][2:0]  rtyp;
    logic [7:0][15:0] rtog;
    int               n_errors = 0;
    int               compares = 0;

    always #2.5 clk = ~clk;

    drl_field drl_field_i (.sw_closed(sw), .in_pin(pin),
        .relay_to_open(rto), .load_on(load));

    drl_core #(.MS_CYCLES(10)) drl_core_i (.clk(clk), .resetn(resetn),
        .in_pin(pin), .in_active_low(act_low), .in_debounce_ms(deb),
        .in_type(ityp), .fault_code_generate_flag(gen),
        .clear_on_request_only_flag(reqo), .fault_send_delay(sdly),
        .fault_clear_delay(cdly), .fault_lamp_select(lamp),
        .fault_mode_select(fmi), .dm11_request(dm11), .dm3_request(dm3),
        .input_state(st), .fault_active(fa), .fault_lamp(fl),
        .fault_mode(fm), .fault_count(fc), .relay_source(src),
        .relay_type(rtyp), .relay_toggle_ms(rtog), .relay_to_open(rto));

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic ms(input int n);
        cyc(n * 10);
    endtask : ms

    task automatic pulse11;
        dm11 = 1'b1;
        cyc(1);
        dm11 = 1'b0;
    endtask : pulse11

    task automatic t_inputs;
        `CHK(st[1:0], 2'h0)
        sw[1:0] = 2'h3;
        cyc(8);
        `CHK(st[1:0], 2'h3)
        sw[1:0] = 2'h0;
        cyc(8);
        `CHK(st[1:0], 2'h0)
        $display("TB: inputs done");
    endtask : t_inputs

    task automatic t_debounce;
        sw[2] = 1'b1;
        ms(1);
        sw[2] = 1'b0;
        ms(4);
        `CHK(st[2], 1'b0)
        sw[2] = 1'b1;
        ms(2);
        `CHK(st[2], 1'b0)
        ms(3);
        `CHK(st[2], 1'b1)
        sw[2] = 1'b0;
        ms(5);
        `CHK(st[2], 1'b0)
        $display("TB: debounce done");
    endtask : t_debounce

    task automatic t_latch;
        sw[3] = 1'b1;
        cyc(8);
        `CHK(st[3], 1'b1)
        sw[3] = 1'b0;
        cyc(8);
        `CHK(st[3], 1'b1)
        sw[3] = 1'b1;
        cyc(8);
        `CHK(st[3], 1'b0)
        sw[3] = 1'b0;
        $display("TB: latch done");
    endtask : t_latch

    task automatic t_fault;
        sw[5:4] = 2'h3;
        ms(1);
        sw[5:4] = 2'h0;
        ms(4);
        `CHK(fa[4], 1'b0)
        sw[5:4] = 2'h3;
        ms(1);
        `CHK(fa[4], 1'b0)
        ms(3);
        `CHK(fa[5:4], 2'h1)
        `CHK(fc[4], 7'h01)
        `CHK(fl[4], 2'h2)
        `CHK(fm[4], 5'h1F)
        sw[5:4] = 2'h0;
        ms(1);
        `CHK(fa[4], 1'b1)
        ms(4);
        `CHK(fa[4], 1'b0)
        `CHK(fc[4], 7'h01)
        $display("TB: fault done");
    endtask : t_fault

    task automatic t_request;
        sw[6] = 1'b1;
        ms(3);
        `CHK(fa[6], 1'b1)
        `CHK(fl[6], 2'h3)
        `CHK(fm[6], 5'h15)
        pulse11;
        cyc(2);
        `CHK(fa[6], 1'b1)
        sw[6] = 1'b0;
        ms(3);
        `CHK(fa[6], 1'b1)
        pulse11;
        cyc(2);
        `CHK(fa[6], 1'b0)
        `CHK(fc[6], 7'h01)
        sw[6] = 1'b1;
        ms(3);
        `CHK(fc[6], 7'h02)
        sw[6] = 1'b0;
        ms(3);
        pulse11;
        dm3 = 1'b1;
        cyc(1);
        dm3 = 1'b0;
        cyc(2);
        `CHK(fc[6], 7'h00)
        $display("TB: request done");
    endtask : t_request

    task automatic t_relay;
        int k;
        `CHK(rto[5:0], 6'h00)
        src = 8'h2F;
        cyc(3);
        `CHK(rto[5:0], 6'h07)
        `CHK(load[0], 1'b1)
        src = 8'h00;
        cyc(3);
        `CHK(rto[5:0], 6'h0C)
        src = 8'h0C;
        cyc(3);
        `CHK(rto[3:2], 2'h2)
        src = 8'h00;
        cyc(3);
        `CHK(rto[3:2], 2'h0)
        `CHK(rto[5], 1'b0)
        rtyp[4] = 3'h5;
        v = rto[4];
        k = 0;
        while (rto[4] === v && k < 40) begin
            k++;
            cyc(1);
        end
        v = rto[4];
        cyc(10);
        `CHK(rto[4], v)
        cyc(20);
        `CHK(rto[4], ~v)
        $display("TB: relay done");
    endtask : t_relay

    task automatic conclude;
        $display("TB: compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        #(5 * 5000);
        n_errors++;
        conclude;
    end

    initial begin
        sw = 12'h000;
        act_low = 12'h002;
        gen = 12'h050;
        reqo = 12'h040;
        deb = '0;
        deb[2] = 16'h0003;
        ityp = '0;
        ityp[1] = 2'h1;
        ityp[3] = 2'h2;
        sdly = '0;
        sdly[4] = 16'h0002;
        sdly[5] = 16'h0002;
        sdly[6] = 16'h0001;
        cdly = '0;
        cdly[4] = 16'h0003;
        cdly[6] = 16'h0001;
        lamp = '0;
        lamp[4] = 2'h2;
        lamp[6] = 2'h3;
        fmi = '0;
        fmi[4] = 5'h16;
        fmi[6] = 5'h15;
        dm11 = 1'b0;
        dm3 = 1'b0;
        src = 8'h00;
        rtyp = {3'h1, 3'h1, 3'h0, 3'h0, 3'h4, 3'h3, 3'h2, 3'h1};
        rtog = '0;
        rtog[4] = 16'h0002;
        cyc(16);
        resetn = 1'b1;
        cyc(20);
        t_inputs;
        t_debounce;
        t_latch;
        t_fault;
        t_request;
        t_relay;
        conclude;
    end
endmodule : test_discrete_input_relay_output_logic
`default_nettype wire
